// file: nvm_array_model.sv
// Behavioural model of the flash and EEPROM arrays
`timescale 1ns/100ps
module nvm_array_model
import nvm_cmd_pkg::*;
#(
    parameter int DLY = 20
) (
    input wire logic                 core_clk,
    input wire logic                 rstn,
    input wire nvm_cmd_pkg::arr_req_s arrReq,
    input wire logic                 failNext,
    input wire logic [15:0]          memRdAddr,
    output logic                     arrayDone,
    output logic                     arrayFail,
    output logic [7:0]               memRdRaw
);
    import nvm_cmd_pkg::*;
    logic [7:0] cnt_ff;
    // Raw data depends on the address so a blanked read is visible
    assign memRdRaw = memRdAddr[7:0] ^ 8'h5A;
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            cnt_ff <= 8'h00;
        else if (arrReq.start)
            cnt_ff <= 8'(DLY);
        else if (cnt_ff != 8'h00)
            cnt_ff <= cnt_ff - 8'h01;
    end
    // Outside the done pulse the fail line shows the opposite value
    always_comb
    begin
        arrayDone = (cnt_ff == 8'h01);
        arrayFail = arrayDone ? failNext : !failNext;
    end
endmodule // nvm_array_model

// file: nvm_cmd_pkg.sv
// Constants and carrier types for the nonvolatile memory command controller
package nvm_cmd_pkg;

    // Register indices; byte address on the bus is four times the index
    localparam logic [3:0] IDX_CMD     = 4'h0;
    localparam logic [3:0] IDX_PROT    = 4'h1;
    localparam logic [3:0] IDX_STATE   = 4'h2;
    localparam logic [3:0] IDX_IRQEN   = 4'h3;
    localparam logic [3:0] IDX_IRQFLAG = 4'h4;
    localparam logic [3:0] IDX_FUSEL   = 4'h6;
    localparam logic [3:0] IDX_FUSEH   = 4'h7;
    localparam logic [3:0] IDX_ADDRL   = 4'h8;
    localparam logic [3:0] IDX_ADDRH   = 4'h9;

    // Field positions
    localparam int CMD_MSB      = 2;
    localparam int APP_WP_BIT   = 0;
    localparam int BOOT_LK_BIT  = 1;
    localparam int FLASH_BIT    = 0;
    localparam int EE_BIT       = 1;
    localparam int FAULT_BIT    = 2;
    localparam int EE_IDLE_BIT  = 0;

    // Reset values
    localparam logic [7:0]  RST_BYTE = 8'h00;
    localparam logic [15:0] RST_HALF = 16'h0000;
    localparam logic [7:0]  PB_ONES  = 8'hFF;

    // Timing
    localparam logic [2:0] KEY_WINDOW  = 3'h4;
    localparam logic [2:0] CLEAR_TICKS = 3'h7;

    // AHB encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    typedef enum logic [2:0] {
        CMD_NONE   = 3'h0,
        CMD_WRITE  = 3'h1,
        CMD_ERASE  = 3'h2,
        CMD_ERWR   = 3'h3,
        CMD_PBCLR  = 3'h4,
        CMD_CHIP   = 3'h5,
        CMD_EEWIPE = 3'h6,
        CMD_FUSE   = 3'h7
    } cmd_e;

    // Byte store into the page buffer by the core or program port
    typedef struct packed {
        logic        valid;
        logic [15:0] addr;
        logic [7:0]  data;
    } pb_store_s;

    // Operation handed to the memory arrays
    typedef struct packed {
        logic        start;
        cmd_e        op;
        logic        toEeprom;
        logic        keepEeprom;
        logic [15:0] addr;
        logic [15:0] fuseData;
    } arr_req_s;

endpackage

// file: nvm_cmd_properties.sv
// Port-level concurrent checks for the memory command controller
`timescale 1ns/100ps
module nvm_cmd_properties
import nvm_cmd_pkg::*;
#(
    parameter logic [15:0] EE_BASE = 16'h1400,
    parameter logic [15:0] EE_END  = 16'h1500
) (
    input wire logic                 core_clk,
    input wire logic                 rstn,
    input wire logic                 hreadyout,
    input wire logic                 hresp,
    input wire logic                 cpuHalt,
    input wire logic                 sleepReq,
    input wire logic                 sleepIsIdle,
    input wire logic                 keepEepromFuse,
    input wire logic                 ctrlAsleep,
    input wire logic                 clockHold,
    input wire logic                 wakeReq,
    input wire nvm_cmd_pkg::arr_req_s arrReq
);
    import nvm_cmd_pkg::*;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus stalled or error response");
    a_start_pulse: assert property (arrReq.start |=> !arrReq.start)
        else $error("array start longer than one cycle");
    a_pbc_nostart: assert property (arrReq.start |-> !(arrReq.op inside {CMD_NONE, CMD_PBCLR}))
        else $error("array started with no command or buffer clear");
    a_ee_target: assert property (arrReq.start && arrReq.op inside {CMD_WRITE, CMD_ERASE, CMD_ERWR}
        |-> arrReq.toEeprom == (arrReq.addr >= EE_BASE && arrReq.addr < EE_END))
        else $error("page operation aimed at wrong memory");
    a_keep_fuse: assert property (arrReq.start && arrReq.op == CMD_CHIP |-> arrReq.keepEeprom == keepEepromFuse)
        else $error("chip erase ignores keep fuse");
    a_flash_stall: assert property (arrReq.start && !arrReq.toEeprom && arrReq.op == CMD_WRITE |-> ##[0:1] cpuHalt)
        else $error("flash write did not stall core");
    a_ee_nostall: assert property (arrReq.start && arrReq.toEeprom && arrReq.op == CMD_WRITE |=> !cpuHalt)
        else $error("eeprom write stalled core");
    a_wake_idle: assert property (wakeReq |-> $past(sleepReq && sleepIsIdle))
        else $error("wake request outside idle sleep");
    a_sleep_idle: assert property (ctrlAsleep |-> $past(sleepReq) && !clockHold)
        else $error("controller asleep while busy or awake");
    a_hold_busy: assert property (clockHold |-> $past(sleepReq) && !ctrlAsleep)
        else $error("clock hold without sleep or while asleep");
    c_start: cover property (arrReq.start);
    c_hold: cover property (clockHold);
    c_wake: cover property (wakeReq);
endmodule // nvm_cmd_properties

// file: nvm_command_controller.sv
// Register front end and command sequencer of the nonvolatile memory controller
//
// The AHB-Lite register port was left to the implementer.
`timescale 1ns/100ps
module nvm_command_controller #(
    parameter int          PB_BYTES   = 32,
    parameter logic [15:0] EE_BASE    = 16'h1400,
    parameter logic [15:0] EE_END     = 16'h1500,
    parameter logic [15:0] FLASH_BASE = 16'h8000,
    parameter logic [15:0] APP_BASE   = 16'h8400
) (
    input  wire logic                  core_clk,
    input  wire logic                  rstn,
    // AHB-Lite slave
    input  wire logic                  hsel,
    input  wire logic [31:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output logic                       hreadyout,
    output logic [31:0]                hrdata,
    output logic                       hresp,
    // Core side
    input  wire logic                  keyWritten,
    input  wire logic                  instrRetired,
    input  wire logic                  fromDebugPort,
    input  wire logic                  execInBoot,
    input  wire nvm_cmd_pkg::pb_store_s pbStore,
    input  wire logic [15:0]           memRdAddr,
    input  wire logic [7:0]            memRdRaw,
    output logic [7:0]                 memRdData,
    output logic                       cpuHalt,
    output logic                       irqReq,
    // Power management
    input  wire logic                  sleepReq,
    input  wire logic                  sleepIsIdle,
    input  wire logic                  wakeEvt,
    output logic                       ctrlAsleep,
    output logic                       clockHold,
    output logic                       wakeReq,
    // Array side
    input  wire logic                  keepEepromFuse,
    input  wire logic                  arrayDone,
    input  wire logic                  arrayFail,
    input  wire logic [$clog2(PB_BYTES)-1:0] pbRdIdx,
    output nvm_cmd_pkg::arr_req_s       arrReq,
    output logic [7:0]                 pbRdData,
    output logic                       pbRdMarked
);
    import nvm_cmd_pkg::*;

    localparam int IW = $clog2(PB_BYTES);

    typedef enum logic [1:0] {ST_IDLE, ST_BUSY, ST_CLEAR} seq_e;

    seq_e          seq_ff;
    logic [2:0]    cmd_ff;
    logic          appWp_ff;
    logic          bootLk_ff;
    logic          bootLkEff_ff;
    logic          inBootPrev_ff;
    logic          flashBusy_ff;
    logic          eeprom_active_ff;
    logic          fault_ff;
    logic          irqEn_ff;
    logic          eeFlag_ff;
    logic [15:0]   fuse_ff;
    logic [15:0]   addr_ff;
    logic [2:0]    keyCnt_ff;
    logic [2:0]    clrCnt_ff;
    logic [7:0]    pb_ff [PB_BYTES];
    logic [PB_BYTES-1:0] mark_ff;
    logic          pbSect_ff;
    logic          pbMixed_ff;
    logic          wrPend_ff;
    logic [3:0]    wrIdx_ff;
    logic          wrDbg_ff;
    logic          hready_ff;
    logic [31:0]   hrdata_ff;
    arr_req_s      arrReq_ff;
    logic [7:0]    memRd_ff;
    logic          halt_ff;
    logic          irq_ff;
    logic          asleep_ff;
    logic          hold_ff;
    logic          wake_ff;
    logic [7:0]    pbRd_ff;
    logic          pbMk_ff;

    logic          addrPhase;
    logic [3:0]    rdIdx;
    logic [7:0]    wByte;
    logic          cmdWr;
    cmd_e          newCmd;
    logic          addrIsEe;
    logic          addrIsBoot;
    logic          launch;
    logic          preFail;
    logic          pbClear;
    logic          storeIsEe;

    assign addrPhase = hsel && hready && (htrans == HTRANS_NONSEQ);
    assign rdIdx     = haddr[5:2];
    assign wByte     = hwdata[7:0];
    assign newCmd    = cmd_e'(hwdata[CMD_MSB:0]);
    // Key must have been written within the last four instructions
    assign cmdWr     = wrPend_ff && (wrIdx_ff == IDX_CMD) && (keyCnt_ff != 3'h0);
    assign addrIsEe   = (addr_ff >= EE_BASE) && (addr_ff < EE_END);
    assign addrIsBoot = (memRdAddr >= FLASH_BASE) && (memRdAddr < APP_BASE);
    assign storeIsEe  = (pbStore.addr >= EE_BASE) && (pbStore.addr < EE_END);

    // Which commands actually start; fuse program from the core is dropped
    always_comb
    begin
        launch = 1'b0;
        if (cmdWr && seq_ff == ST_IDLE)
        begin
            unique case (newCmd)
                CMD_NONE:   launch = 1'b0;
                CMD_WRITE:  launch = 1'b1;
                CMD_ERASE:  launch = |mark_ff;
                CMD_ERWR:   launch = 1'b1;
                CMD_PBCLR:  launch = 1'b0;
                CMD_CHIP:   launch = 1'b1;
                CMD_EEWIPE: launch = 1'b1;
                CMD_FUSE:   launch = wrDbg_ff;
            endcase
        end
    end

    // Errors detectable before the array starts
    always_comb
    begin
        preFail = 1'b0;
        if (newCmd == CMD_WRITE || newCmd == CMD_ERASE || newCmd == CMD_ERWR)
        begin
            preFail = pbMixed_ff;
            if (!addrIsEe && addr_ff >= FLASH_BASE)
            begin
                if (addr_ff >= APP_BASE)
                    preFail = preFail || appWp_ff;
                else
                    preFail = preFail || !wrDbg_ff;
            end
        end
    end

    assign pbClear = wakeEvt
        || (seq_ff == ST_CLEAR && clrCnt_ff == 3'h1)
        || (seq_ff == ST_BUSY && arrayDone && arrReq_ff.op != CMD_FUSE);

    // Bus data phase bookkeeping; zero wait state, always OKAY
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            wrPend_ff <= 1'b0;
            wrIdx_ff  <= 4'h0;
            wrDbg_ff  <= 1'b0;
            hready_ff <= 1'b1;
        end
        else
        begin
            wrPend_ff <= addrPhase && hwrite;
            wrIdx_ff  <= rdIdx;
            wrDbg_ff  <= fromDebugPort;
            hready_ff <= 1'b1;
        end
    end

    // Read data is prepared at the address phase so it leaves a flop
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            hrdata_ff <= 32'h0000_0000;
        else if (addrPhase && !hwrite)
        begin
            hrdata_ff <= 32'h0000_0000;
            unique case (rdIdx)
                IDX_CMD:     hrdata_ff[CMD_MSB:0] <= cmd_ff;
                IDX_PROT:    hrdata_ff[1:0] <= {bootLk_ff, appWp_ff};
                IDX_STATE:   hrdata_ff[2:0] <= {fault_ff, eeprom_active_ff, flashBusy_ff};
                IDX_IRQEN:   hrdata_ff[EE_IDLE_BIT] <= irqEn_ff;
                IDX_IRQFLAG: hrdata_ff[EE_IDLE_BIT] <= eeFlag_ff;
                IDX_FUSEL:   hrdata_ff[15:0] <= fuse_ff;
                IDX_FUSEH:   hrdata_ff[7:0] <= fuse_ff[15:8];
                IDX_ADDRL:   hrdata_ff[15:0] <= addr_ff;
                IDX_ADDRH:   hrdata_ff[7:0] <= addr_ff[15:8];
                default:     hrdata_ff <= 32'h0000_0000;
            endcase
        end
    end

    // Key window counts retired instructions after the key
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            keyCnt_ff <= 3'h0;
        else if (keyWritten)
            keyCnt_ff <= KEY_WINDOW;
        else if (cmdWr)
            keyCnt_ff <= 3'h0;
        else if (instrRetired && keyCnt_ff != 3'h0)
            keyCnt_ff <= keyCnt_ff - 3'h1;
    end

    // Command register; unkeyed writes leave it untouched
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            cmd_ff <= RST_BYTE[2:0];
        else if (cmdWr)
            cmd_ff <= hwdata[CMD_MSB:0];
        else if (seq_ff != ST_IDLE && pbClear)
            cmd_ff <= RST_BYTE[2:0];
    end

    // Protection bits are sticky until reset
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            appWp_ff  <= 1'b0;
            bootLk_ff <= 1'b0;
        end
        else if (wrPend_ff && wrIdx_ff == IDX_PROT)
        begin
            appWp_ff  <= appWp_ff || wByte[APP_WP_BIT];
            bootLk_ff <= bootLk_ff || (wByte[BOOT_LK_BIT] && execInBoot);
        end
    end

    // Lock engages on the first exit from the boot section after it is set
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            inBootPrev_ff <= 1'b0;
            bootLkEff_ff  <= 1'b0;
        end
        else
        begin
            inBootPrev_ff <= execInBoot;
            if (bootLk_ff && inBootPrev_ff && !execInBoot)
                bootLkEff_ff <= 1'b1;
        end
    end

    // Filtered read and fetch path
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            memRd_ff <= RST_BYTE;
        else
            memRd_ff <= (bootLkEff_ff && addrIsBoot) ? RST_BYTE : memRdRaw;
    end

    // Interrupt enable and the idle flag; a set beats a same-cycle clear
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            irqEn_ff  <= 1'b0;
            eeFlag_ff <= 1'b0;
        end
        else
        begin
            if (wrPend_ff && wrIdx_ff == IDX_IRQEN)
                irqEn_ff <= wByte[EE_IDLE_BIT];
            if (!eeprom_active_ff)
                eeFlag_ff <= 1'b1;
            else if (wrPend_ff && wrIdx_ff == IDX_IRQFLAG && wByte[EE_IDLE_BIT])
                eeFlag_ff <= 1'b0;
        end
    end

    // Level request follows the flag, not its edges
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            irq_ff  <= 1'b0;
            wake_ff <= 1'b0;
        end
        else
        begin
            irq_ff  <= irqEn_ff && eeFlag_ff;
            wake_ff <= irqEn_ff && eeFlag_ff && sleepReq && sleepIsIdle;
        end
    end

    // Fuse data and last address; stores into the buffer update the address
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            fuse_ff <= RST_HALF;
            addr_ff <= RST_HALF;
        end
        else
        begin
            if (wrPend_ff && wrIdx_ff == IDX_FUSEL)
                fuse_ff <= hwdata[15:0];
            else if (wrPend_ff && wrIdx_ff == IDX_FUSEH)
                fuse_ff[15:8] <= wByte;
            if (pbStore.valid)
                addr_ff <= pbStore.addr;
            else if (wrPend_ff && wrIdx_ff == IDX_ADDRL)
                addr_ff <= hwdata[15:0];
            else if (wrPend_ff && wrIdx_ff == IDX_ADDRH)
                addr_ff[15:8] <= wByte;
        end
    end

    // Page buffer: stores AND into old content, marks track written bytes
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            for (int i = 0; i < PB_BYTES; i++)
                pb_ff[i] <= PB_ONES;
            mark_ff    <= '0;
            pbSect_ff  <= 1'b0;
            pbMixed_ff <= 1'b0;
        end
        else if (pbClear)
        begin
            for (int i = 0; i < PB_BYTES; i++)
                pb_ff[i] <= PB_ONES;
            mark_ff    <= '0;
            pbMixed_ff <= 1'b0;
        end
        else if (pbStore.valid)
        begin
            pb_ff[pbStore.addr[IW-1:0]] <= pb_ff[pbStore.addr[IW-1:0]] & pbStore.data;
            mark_ff[pbStore.addr[IW-1:0]] <= 1'b1;
            if (mark_ff == '0)
                pbSect_ff <= storeIsEe;
            else if (pbSect_ff != storeIsEe)
                pbMixed_ff <= 1'b1;
        end
    end

    // Buffer read-out to the arrays; EEPROM programs only marked bytes
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            pbRd_ff <= PB_ONES;
            pbMk_ff <= 1'b0;
        end
        else
        begin
            pbRd_ff <= pb_ff[pbRdIdx];
            pbMk_ff <= mark_ff[pbRdIdx];
        end
    end

    // Sequencer
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            seq_ff    <= ST_IDLE;
            clrCnt_ff <= 3'h0;
        end
        else
        begin
            unique case (seq_ff)
                ST_IDLE:
                begin
                    if (cmdWr && newCmd == CMD_PBCLR)
                    begin
                        seq_ff    <= ST_CLEAR;
                        clrCnt_ff <= CLEAR_TICKS;
                    end
                    else if (launch && !preFail)
                        seq_ff <= ST_BUSY;
                end
                ST_BUSY:
                    if (arrayDone)
                        seq_ff <= ST_IDLE;
                ST_CLEAR:
                begin
                    clrCnt_ff <= clrCnt_ff - 3'h1;
                    if (clrCnt_ff == 3'h1)
                        seq_ff <= ST_IDLE;
                end
            endcase
        end
    end

    // Array request and busy flags
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            arrReq_ff    <= '0;
            flashBusy_ff <= 1'b0;
            eeprom_active_ff    <= 1'b0;
            fault_ff     <= 1'b0;
        end
        else
        begin
            arrReq_ff.start <= 1'b0;
            if (seq_ff == ST_IDLE && launch)
            begin
                fault_ff <= preFail;
                if (!preFail)
                begin
                    arrReq_ff.start      <= 1'b1;
                    arrReq_ff.op         <= newCmd;
                    arrReq_ff.toEeprom   <= addrIsEe;
                    arrReq_ff.keepEeprom <= keepEepromFuse;
                    arrReq_ff.addr       <= addr_ff;
                    arrReq_ff.fuseData   <= fuse_ff;
                    eeprom_active_ff    <= (newCmd == CMD_EEWIPE) || (newCmd == CMD_CHIP && !keepEepromFuse)
                                    || (newCmd != CMD_CHIP && newCmd != CMD_FUSE && addrIsEe);
                    flashBusy_ff <= (newCmd == CMD_CHIP) || (newCmd == CMD_FUSE)
                                    || (newCmd != CMD_EEWIPE && !addrIsEe);
                end
            end
            else if (seq_ff == ST_BUSY && arrayDone)
            begin
                eeprom_active_ff    <= 1'b0;
                flashBusy_ff <= 1'b0;
                fault_ff     <= arrayFail;
            end
        end
    end

    // Halt the core for flash work, EEPROM wipe and buffer clear only
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            halt_ff <= 1'b0;
        else
            halt_ff <= (seq_ff == ST_CLEAR && clrCnt_ff != 3'h1)
                || (seq_ff == ST_IDLE && cmdWr && newCmd == CMD_PBCLR)
                || (seq_ff == ST_BUSY && !arrayDone && (flashBusy_ff || arrReq_ff.op == CMD_EEWIPE));
    end

    // Sleep follows the system unless a running command or buffer clear holds the clock on
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            asleep_ff <= 1'b0;
            hold_ff   <= 1'b0;
        end
        else
        begin
            asleep_ff <= sleepReq && seq_ff == ST_IDLE;
            hold_ff   <= sleepReq && seq_ff != ST_IDLE;
        end
    end

    assign hreadyout  = hready_ff;
    assign hrdata     = hrdata_ff;
    assign hresp      = 1'b0 & hready_ff;
    assign memRdData  = memRd_ff;
    assign cpuHalt    = halt_ff;
    assign irqReq     = irq_ff;
    assign ctrlAsleep = asleep_ff;
    assign clockHold  = hold_ff;
    assign wakeReq    = wake_ff;
    assign arrReq     = arrReq_ff;
    assign pbRdData   = pbRd_ff;
    assign pbRdMarked = pbMk_ff;

endmodule // nvm_command_controller

// file: testbench.sv
// Self-checking bench for the memory command controller
`timescale 1ns/100ps
module testbench;
    import nvm_cmd_pkg::*;
    localparam logic [15:0] EE_A = 16'h1402;
    logic core_clk = 1'h0, rstn = 1'h0, hsel = 1'h0, hwrite = 1'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic keyWritten = 1'h0, instrRetired = 1'h0, fromDebugPort = 1'h0, execInBoot = 1'h0;
    logic sleepReq = 1'h0, sleepIsIdle = 1'h0, wakeEvt = 1'h0, keepEepromFuse = 1'h1, failNext = 1'h0;
    pb_store_s pbStore = '0;
    logic [15:0] memRdAddr = 16'h0;
    logic [4:0] pbRdIdx = 5'h0;
    logic [7:0] memRdRaw, memRdData, pbRdData;
    logic hreadyout, hresp, cpuHalt, irqReq, ctrlAsleep, clockHold, wakeReq, arrayDone, arrayFail, pbRdMarked;
    arr_req_s arrReq;
    int fail_count = 0, tests_run = 0, starts = 0, n;

    always #12.5 core_clk = ~core_clk;
    always @(posedge core_clk) if (arrReq.start === 1'h1) starts++;

    nvm_command_controller uut (.core_clk, .rstn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hreadyout, .hrdata, .hresp, .keyWritten, .instrRetired, .fromDebugPort,
        .execInBoot, .pbStore, .memRdAddr, .memRdRaw, .memRdData, .cpuHalt, .irqReq, .sleepReq,
        .sleepIsIdle, .wakeEvt, .ctrlAsleep, .clockHold, .wakeReq, .keepEepromFuse, .arrayDone,
        .arrayFail, .pbRdIdx, .arrReq, .pbRdData, .pbRdMarked);
    nvm_array_model far (.core_clk, .rstn, .arrReq, .failNext, .memRdAddr, .arrayDone, .arrayFail, .memRdRaw);

    task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("BAD %s expected %h seen %h", s, exp, seen);
        end
    endtask
    // Whole-word single transfer; waits on hready in both phases
    task automatic bus(input logic w, input logic [3:0] i, input logic [31:0] d);
        @(posedge core_clk);
        hsel <= 1'h1;
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        haddr <= {26'h0, i, 2'h0};
        do @(posedge core_clk); while (hreadyout !== 1'h1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge core_clk); while (hreadyout !== 1'h1);
        q = hrdata;
    endtask
    task automatic rd(input string s, input logic [3:0] i, input logic [31:0] e);
        bus(1'h0, i, 32'h0);
        chk(s, q, e);
    endtask
    task automatic cmd(input logic [2:0] c);
        keyWritten <= 1'h1;
        @(posedge core_clk);
        keyWritten <= 1'h0;
        bus(1'h1, IDX_CMD, {29'h0, c});
    endtask
    task automatic store(input logic [15:0] a, input logic [7:0] d);
        @(posedge core_clk);
        pbStore <= '{1'h1, a, d};
        @(posedge core_clk);
        pbStore <= '0;
    endtask
    task automatic idle();
        n = 0;
        while (arrayDone !== 1'h1 && n < 200)
        begin
            @(posedge core_clk);
            n++;
        end
        repeat (3) @(negedge core_clk);
    endtask
    task automatic report_and_stop();
        $display("Checks %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Whole run needs well under 4000 cycles
    initial
    begin
        #500us;
        fail_count++;
        report_and_stop();
    end

    initial
    begin
        repeat (8) @(posedge core_clk);
        rstn <= 1'h1;
        @(posedge core_clk);
        // Idle EEPROM sets the ready flag straight after reset
        for (int i = 0; i < 16; i++) rd("reset value", i[3:0], {31'h0, i == 4});
        chk("buffer ones", pbRdData, 8'hFF);
        bus(1'h1, IDX_FUSEL, 32'h0000_BEEF);
        bus(1'h1, 4'h5, 32'h0000_00FF);
        rd("fuse high", IDX_FUSEH, 32'h0000_00BE);
        rd("reserved", 4'h5, 32'h0);
        bus(1'h1, IDX_IRQEN, 32'h0000_00FF);
        rd("irq enable", IDX_IRQEN, 32'h1);
        bus(1'h1, IDX_IRQFLAG, 32'h1);
        rd("flag idle", IDX_IRQFLAG, 32'h1);
        chk("irq level", irqReq, 1'h1);
        bus(1'h1, IDX_IRQEN, 32'h0);
        repeat (2) @(negedge core_clk);
        chk("irq off", irqReq, 1'h0);
        $display("register test done");

        store(EE_A, 8'hF0);
        store(EE_A, 8'h3C);
        pbRdIdx <= EE_A[4:0];
        rd("last address", IDX_ADDRL, {16'h0, EE_A});
        chk("buffer and", pbRdData, 8'h30);
        chk("marked", pbRdMarked, 1'h1);
        bus(1'h1, IDX_CMD, 32'h1);
        keyWritten <= 1'h1;
        @(posedge core_clk);
        keyWritten <= 1'h0;
        instrRetired <= 1'h1;
        repeat (4) @(posedge core_clk);
        instrRetired <= 1'h0;
        bus(1'h1, IDX_CMD, 32'h1);
        repeat (2) @(posedge core_clk);
        chk("unkeyed start", starts, 0);
        cmd(CMD_WRITE);
        rd("ee busy", IDX_STATE, 32'h2);
        bus(1'h1, IDX_IRQFLAG, 32'h1);
        rd("flag cleared", IDX_IRQFLAG, 32'h0);
        sleepReq <= 1'h1;
        repeat (3) @(negedge core_clk);
        chk("clock hold", clockHold, 1'h1);
        idle();
        chk("asleep", ctrlAsleep, 1'h1);
        chk("buffer reset", pbRdData, 8'hFF);
        sleepIsIdle <= 1'h1;
        bus(1'h1, IDX_IRQEN, 32'h1);
        repeat (3) @(negedge core_clk);
        chk("wake idle", wakeReq, 1'h1);
        sleepIsIdle <= 1'h0;
        store(EE_A, 8'h00);
        repeat (2) @(negedge core_clk);
        chk("no deep wake", wakeReq, 1'h0);
        wakeEvt <= 1'h1;
        @(posedge core_clk);
        wakeEvt <= 1'h0;
        sleepReq <= 1'h0;
        repeat (2) @(negedge core_clk);
        chk("wake clears", pbRdData, 8'hFF);
        $display("eeprom and sleep test done");

        fromDebugPort <= 1'h1;
        for (int c = 1; c < 8; c++)
        begin
            store(EE_A, 8'h00);
            n = starts;
            cmd(c[2:0]);
            repeat (3) @(posedge core_clk);
            chk("launch", starts - n, c != 4);
            if (c != 4) idle(); else repeat (8) @(posedge core_clk);
        end
        fromDebugPort <= 1'h0;
        cmd(CMD_PBCLR);
        n = 0;
        repeat (12) @(negedge core_clk) if (cpuHalt === 1'h1) n++;
        chk("halt cycles", n, 7);
        n = starts;
        cmd(CMD_FUSE);
        repeat (3) @(posedge core_clk);
        chk("core fuse", starts - n, 0);
        $display("command test done");

        store(16'h8400, 8'h00);
        cmd(CMD_WRITE);
        idle();
        failNext <= 1'h1;
        store(EE_A, 8'h00);
        cmd(CMD_WRITE);
        idle();
        failNext <= 1'h0;
        rd("array fault", IDX_STATE, 32'h4);
        bus(1'h1, IDX_PROT, 32'h3);
        rd("protect set", IDX_PROT, 32'h1);
        store(16'h8400, 8'h00);
        n = starts;
        cmd(CMD_WRITE);
        rd("protect fault", IDX_STATE, 32'h4);
        chk("protect start", starts - n, 0);
        execInBoot <= 1'h1;
        memRdAddr <= 16'h8010;
        bus(1'h1, IDX_PROT, 32'h2);
        rd("boot lock", IDX_PROT, 32'h3);
        chk("lock pending", memRdData, 8'h4A);
        execInBoot <= 1'h0;
        repeat (3) @(negedge core_clk);
        chk("boot blank", memRdData, 8'h00);
        $display("protection test done");
        report_and_stop();
    end
endmodule // testbench

bind nvm_command_controller nvm_cmd_properties #(.EE_BASE(EE_BASE), .EE_END(EE_END)) props (.core_clk, .rstn,
    .hreadyout, .hresp, .cpuHalt, .sleepReq, .sleepIsIdle, .keepEepromFuse, .ctrlAsleep, .clockHold,
    .wakeReq, .arrReq);
